// *** shared/wtim_pkg.sv ***
// package: constants, register map and types of the watch and interval timer
package wtim_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MODE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATE = 4'hC;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int unsigned MODE_W = 8;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_BIT_WATCH = 0;
  localparam int unsigned IRQ_BIT_INTERVAL = 1;
  localparam int unsigned STATE_PRESC_LSB = 0;
  localparam int unsigned STATE_COUNT_LSB = 16;

  // ----------------------------------------------------------------
  // counter geometry and tap positions
  // ----------------------------------------------------------------
  localparam int unsigned PRESC_W = 11;
  localparam int unsigned COUNT_W = 5;
  localparam int unsigned PERIPH_DIV_LOG2 = 7;
  localparam int unsigned COUNT_TAP = 9;
  localparam int unsigned INTERVAL_TAP_BASE = 4;
  localparam int unsigned WATCH_TAP_SHORT = 4;
  localparam int unsigned WATCH_TAP_LONG = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WPER_2P14 = 2'h0,
    WPER_2P13 = 2'h1,
    WPER_2P5 = 2'h2,
    WPER_2P4 = 2'h3
  } wtim_wper_t;

  typedef struct packed {
    logic tick_source_sel;
    logic [2:0] interval_sel;
    wtim_wper_t watch_period_sel;
    logic counter_run;
    logic op_enable;
  } wtim_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } wtim_req_t;

endpackage

// *** logic/wtim_tick_gen.sv ***
// tick clock source: peripheral clock divided down, or the synchronised subsystem clock
`timescale 1ns/10ps
module wtim_tick_gen #(
  parameter int unsigned DIV_LOG2 = wtim_pkg::PERIPH_DIV_LOG2
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // control
  input wire logic enable_in,
  input wire logic source_sel_in,
  // subsystem clock pin
  input wire logic sub_clk_in,
  // tick pulse
  output logic tick_out
);

  // refused at elaboration, before any clock runs
  if (DIV_LOG2 < 1 || DIV_LOG2 > 16) begin : g_bad_div
    $error("wtim_tick_gen: DIV_LOG2 out of range");
  end

  // ----------------------------------------------------------------
  // subsystem clock synchroniser
  // ----------------------------------------------------------------
  logic [2:0] sync_q;
  logic level_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], sub_clk_in};
    end
  end

  // a level is accepted only once the second and third stage agree
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      level_q <= 1'b0;
    end else if (sync_q[1] == sync_q[2]) begin
      level_q <= sync_q[2];
    end
  end

  // ----------------------------------------------------------------
  // peripheral divider
  // ----------------------------------------------------------------
  logic [DIV_LOG2-1:0] div_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_q <= '0;
    end else if (!enable_in) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // tick selection
  // ----------------------------------------------------------------
  logic sub_rise;
  logic div_wrap;

  assign sub_rise = level_q == 1'b0 && sync_q[1] == sync_q[2] && sync_q[2];
  assign div_wrap = &div_q;
  assign tick_out = enable_in && (source_sel_in ? sub_rise : div_wrap); // RL11

endmodule

// *** logic/wtim_prescaler.sv ***
// prescaler: free binary count of tick pulses with one rollover tap per bit
`timescale 1ns/10ps
module wtim_prescaler #(
  parameter int unsigned WIDTH = wtim_pkg::PRESC_W
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // control
  input wire logic enable_in,
  input wire logic tick_in,
  // state and taps
  output logic [WIDTH-1:0] count_out,
  output logic [WIDTH:1] tap_out
);

  // refused at elaboration, before any clock runs
  if (WIDTH < 10 || WIDTH > 24) begin : g_bad_width
    $error("wtim_prescaler: WIDTH must cover the counter tap");
  end

  logic [WIDTH-1:0] presc_q;

  // cleared whenever operation is disabled
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      presc_q <= '0;
    end else if (!enable_in) begin
      presc_q <= '0; // RL12
    end else if (tick_in) begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // tap k fires on the tick that completes 2^k ticks
  genvar k;
  generate
    for (k = 1; k <= WIDTH; k++) begin : g_tap
      assign tap_out[k] = tick_in && (&presc_q[k-1:0]);
    end
  endgenerate

  assign count_out = presc_q;

endmodule

// *** logic/wtim_top.sv ***
// watch and interval timer: mode register, 5-bit counter, interrupts and register port
`timescale 1ns/10ps
// Function
// RL1 - the block raises the watch interrupt periodically from the selected tick clock.
// RL2 - watch counting runs only while both op_enable and counter_run are one.
// RL3 - with op_enable and counter_run cleared the 5-bit counter is cleared and halts.
// RL4 - clearing only counter_run clears the 5-bit counter but keeps the prescaler running.
// RL5 - the first watch interrupt after a zero-second start may be off by up to 2^9 ticks.
// RL6 - the watch period field selects 2^14, 2^13, 2^5 or 2^4 ticks for codes 0 to 3.
// RL7 - the interval interrupt repeats every selected interval while op_enable is set.
// RL8 - the interval field selects 2^(4+code) ticks, from 2^4 up to 2^11.
// RL9 - interval counting follows op_enable alone, whatever counter_run holds.
// RL10 - the first watch interrupt may come late, every later one comes exactly on period.
// RL11 - the tick is the system clock divided by 2^7, or the subsystem clock when selected.
// RL12 - clearing op_enable clears the prescaler and the 5-bit counter and stops counting.
// RL13 - reset loads the mode register with zero, stopping both functions.
// RL14 - software keeps tick source and interval field stable while the timer runs.
// RL15 - the 5-bit counter steps on the 2^9 prescaler tap, short watch periods use taps.
// RL16 - each watch or interval request is a single-cycle pulse on the system clock.
module wtim_top (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // register port
  input wire logic [wtim_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [wtim_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [wtim_pkg::DATA_W-1:0] reg_rdata_out,
  // subsystem clock pin
  input wire logic sub_clk_in,
  // interrupt outputs
  output logic watch_irq_out,
  output logic interval_irq_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // request bundle
  // ----------------------------------------------------------------
  wtim_pkg::wtim_req_t req;

  assign req.addr = reg_addr_in;
  assign req.wdata = reg_wdata_in;
  assign req.wr = reg_wr_in;
  assign req.rd = reg_rd_in;

  logic wr_mode;
  logic wr_status;
  logic wr_mask;

  assign wr_mode = req.wr && req.addr == wtim_pkg::OFS_MODE;
  assign wr_status = req.wr && req.addr == wtim_pkg::OFS_IRQ_STATUS;
  assign wr_mask = req.wr && req.addr == wtim_pkg::OFS_IRQ_MASK;

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  wtim_pkg::wtim_mode_t mode_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_q <= wtim_pkg::wtim_mode_t'(wtim_pkg::MODE_RESET); // RL13
    end else if (wr_mode) begin
      mode_q <= wtim_pkg::wtim_mode_t'(req.wdata[wtim_pkg::MODE_W-1:0]);
    end
  end

  logic op_enable;
  logic counter_run;
  logic watch_run;

  assign op_enable = mode_q.op_enable;
  assign counter_run = mode_q.counter_run;
  assign watch_run = op_enable && counter_run; // RL2

  // ----------------------------------------------------------------
  // tick source and prescaler
  // ----------------------------------------------------------------
  // source and interval are not retimed on change; software holds them
  // steady while running, so a glitched tick here is not guarded against
  logic tick;
  logic [wtim_pkg::PRESC_W-1:0] presc;
  logic [wtim_pkg::PRESC_W:1] tap;

  wtim_tick_gen #(
    .DIV_LOG2(wtim_pkg::PERIPH_DIV_LOG2)
  ) u_tick (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .enable_in(op_enable),
    .source_sel_in(mode_q.tick_source_sel), // RL11 RL14
    .sub_clk_in(sub_clk_in),
    .tick_out(tick)
  );

  // prescaler follows op_enable only, so the interval side ignores counter_run
  wtim_prescaler #(
    .WIDTH(wtim_pkg::PRESC_W)
  ) u_presc (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .enable_in(op_enable), // RL9 RL12 RL4
    .tick_in(tick),
    .count_out(presc),
    .tap_out(tap)
  );

  // ----------------------------------------------------------------
  // 5-bit watch counter
  // ----------------------------------------------------------------
  logic [wtim_pkg::COUNT_W-1:0] count_q;
  logic count_step;

  assign count_step = watch_run && tap[wtim_pkg::COUNT_TAP]; // RL15

  // clearing counter_run restarts the seconds count from zero but the
  // prescaler phase is kept, which is why the first period can be off
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_q <= '0;
    end else if (!watch_run) begin
      count_q <= '0; // RL3 RL4 RL12 RL5
    end else if (count_step) begin
      count_q <= count_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // watch period selection
  // ----------------------------------------------------------------
  logic watch_hit;

  // long periods end when the counter wraps (2^14) or its low four bits wrap (2^13)
  always_comb begin
    watch_hit = 1'b0;
    unique case (mode_q.watch_period_sel)
      wtim_pkg::WPER_2P14: begin
        watch_hit = count_step && (&count_q); // RL6 RL10
      end
      wtim_pkg::WPER_2P13: begin
        watch_hit = count_step && (&count_q[wtim_pkg::COUNT_W-2:0]); // RL6
      end
      wtim_pkg::WPER_2P5: begin
        watch_hit = watch_run && tap[wtim_pkg::WATCH_TAP_LONG]; // RL6 RL15
      end
      wtim_pkg::WPER_2P4: begin
        watch_hit = watch_run && tap[wtim_pkg::WATCH_TAP_SHORT]; // RL6 RL15
      end
    endcase
  end

  // ----------------------------------------------------------------
  // interval selection
  // ----------------------------------------------------------------
  logic interval_hit;
  logic [3:0] interval_tap_idx;

  assign interval_tap_idx = 4'(wtim_pkg::INTERVAL_TAP_BASE) + {1'b0, mode_q.interval_sel}; // RL8

  always_comb begin
    interval_hit = 1'b0;
    for (int i = wtim_pkg::INTERVAL_TAP_BASE; i <= wtim_pkg::PRESC_W; i++) begin
      if (interval_tap_idx == 4'(i)) begin
        interval_hit = op_enable && tap[i]; // RL7 RL9
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt request pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      watch_irq_out <= 1'b0;
    end else begin
      watch_irq_out <= watch_hit; // RL1 RL16
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      interval_irq_out <= 1'b0;
    end else begin
      interval_irq_out <= interval_hit; // RL7 RL16
    end
  end

  // ----------------------------------------------------------------
  // sticky status and mask
  // ----------------------------------------------------------------
  logic [wtim_pkg::IRQ_W-1:0] status_q;
  logic [wtim_pkg::IRQ_W-1:0] mask_q;
  logic [wtim_pkg::IRQ_W-1:0] irq_event;
  logic [wtim_pkg::IRQ_W-1:0] irq_clear;

  assign irq_event[wtim_pkg::IRQ_BIT_WATCH] = watch_irq_out;
  assign irq_event[wtim_pkg::IRQ_BIT_INTERVAL] = interval_irq_out;
  assign irq_clear = wr_status ? req.wdata[wtim_pkg::IRQ_W-1:0] : '0;

  // a new event in the clear cycle survives: set wins over clear
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mask_q <= wtim_pkg::IRQ_MASK_RESET;
    end else if (wr_mask) begin
      mask_q <= req.wdata[wtim_pkg::IRQ_W-1:0];
    end
  end

  assign irq_out = |(status_q & mask_q);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [wtim_pkg::DATA_W-1:0] rdata_d;
  logic [wtim_pkg::DATA_W-1:0] rdata_q;
  logic [wtim_pkg::DATA_W-1:0] state_word;

  always_comb begin
    state_word = '0;
    state_word[wtim_pkg::STATE_PRESC_LSB +: wtim_pkg::PRESC_W] = presc;
    state_word[wtim_pkg::STATE_COUNT_LSB +: wtim_pkg::COUNT_W] = count_q;
  end

  // unmapped offsets read as zero
  always_comb begin
    rdata_d = '0;
    if (req.rd) begin
      unique case (req.addr)
        wtim_pkg::OFS_MODE: begin
          rdata_d[wtim_pkg::MODE_W-1:0] = mode_q;
        end
        wtim_pkg::OFS_IRQ_STATUS: begin
          rdata_d[wtim_pkg::IRQ_W-1:0] = status_q;
        end
        wtim_pkg::OFS_IRQ_MASK: begin
          rdata_d[wtim_pkg::IRQ_W-1:0] = mask_q;
        end
        wtim_pkg::OFS_STATE: begin
          rdata_d = state_word;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

endmodule

// *** test/wtim_top_sva.sv ***
// checker: port-level assertions of the watch and interval timer
`timescale 1ns/10ps
module wtim_top_sva #(
  parameter int SUB_PER = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // register port
  input wire logic [wtim_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [wtim_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [wtim_pkg::DATA_W-1:0] reg_rdata_out,
  // pin and interrupts
  input wire logic sub_clk_in,
  input wire logic watch_irq_out,
  input wire logic interval_irq_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // ----
  // shadows and gap counters
  // ----
  logic [7:0] mode_q;
  logic [1:0] mask_q;
  logic iseen_q, wseen_q, mode_wr, mapped;
  int unsigned icnt_q, wcnt_q, tick_per, ip_exp, wp_exp;
  assign mode_wr = reg_wr_in && (reg_addr_in == wtim_pkg::OFS_MODE);
  assign mapped = reg_addr_in[1:0] == 2'h0;
  always_comb begin
    tick_per = mode_q[7] ? SUB_PER : (1 << wtim_pkg::PERIPH_DIV_LOG2);
    ip_exp = tick_per << (4 + mode_q[6:4]);
    case (mode_q[3:2])
      2'h0: wp_exp = tick_per << 14;
      2'h1: wp_exp = tick_per << 13;
      2'h2: wp_exp = tick_per << 5;
      default: wp_exp = tick_per << 4;
    endcase
  end
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_q <= 8'h00;
      mask_q <= 2'h0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == wtim_pkg::OFS_MODE) mode_q <= reg_wdata_in[7:0];
      if (reg_addr_in == wtim_pkg::OFS_IRQ_MASK) mask_q <= reg_wdata_in[1:0];
    end
  end
  // a mode write restarts both gaps, so only pulses of one setting are compared
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      icnt_q <= 0;
      iseen_q <= 1'b0;
    end else if (mode_wr) begin
      icnt_q <= 0;
      iseen_q <= 1'b0;
    end else if (interval_irq_out) begin
      icnt_q <= 1;
      iseen_q <= 1'b1;
    end else icnt_q <= icnt_q + 1;
  end
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wcnt_q <= 0;
      wseen_q <= 1'b0;
    end else if (mode_wr) begin
      wcnt_q <= 0;
      wseen_q <= 1'b0;
    end else if (watch_irq_out) begin
      wcnt_q <= 1;
      wseen_q <= 1'b1;
    end else wcnt_q <= wcnt_q + 1;
  end
  // ----
  // assertions
  // ----
  chk_rd_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data not zero outside answer cycle");
  chk_mode_read: assert property (
    reg_rd_in && reg_addr_in == wtim_pkg::OFS_MODE |=> reg_rdata_out == {24'h00_0000, mode_q})
    else $error("mode read back wrong");
  chk_unmapped_read: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_watch_pulse: assert property (watch_irq_out |=> !watch_irq_out)
    else $error("watch request longer than one cycle");
  chk_intv_pulse: assert property (interval_irq_out |=> !interval_irq_out)
    else $error("interval request longer than one cycle");
  chk_watch_run: assert property (watch_irq_out |-> ($past(mode_q) & 8'h03) == 8'h03)
    else $error("watch request without enable and run");
  chk_intv_enable: assert property (interval_irq_out |-> ($past(mode_q) & 8'h01) == 8'h01)
    else $error("interval request without enable");
  chk_intv_period: assert property (interval_irq_out && iseen_q |-> icnt_q == ip_exp)
    else $error("interval period wrong");
  chk_watch_period: assert property (watch_irq_out && wseen_q |-> wcnt_q == wp_exp)
    else $error("watch period wrong");
  chk_irq_masked: assert property (mask_q == 2'h0 |-> !irq_out)
    else $error("interrupt high with all masked");
  chk_irq_raise: assert property (interval_irq_out && mask_q[1] && !reg_wr_in |=> irq_out)
    else $error("unmasked interval event did not raise interrupt");
endmodule

// *** test/tb_wtim_top.sv ***
// testbench: directed scenarios for the watch and interval timer
`timescale 1ns/10ps
module tb_wtim_top;
  // ----
  // signals
  // ----
  localparam int SUB_PER = 8;
  logic clk_sys_in, rstn_in, reg_wr_in, reg_rd_in, sub_clk_in;
  logic [wtim_pkg::ADDR_W-1:0] reg_addr_in;
  logic [wtim_pkg::DATA_W-1:0] reg_wdata_in, reg_rdata_out, rv;
  logic watch_irq_out, interval_irq_out, irq_out;
  int fail_count = 0;
  int checks = 0;
  int n;
  wtim_top i_wtim_top (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .sub_clk_in(sub_clk_in), .watch_irq_out(watch_irq_out),
    .interval_irq_out(interval_irq_out), .irq_out(irq_out));
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // free-running pin; the offset keeps its edges away from the sampling edge
  initial begin
    sub_clk_in = 1'b0;
    #1.2;
    forever #(SUB_PER * 2.5) sub_clk_in = ~sub_clk_in;
  end
  // ----
  // shared tasks
  // ----
  task automatic results();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic wait_irq(input bit w, input int lim, output int cyc);
    bit hit;
    hit = 1'b0;
    cyc = 0;
    while (!hit && cyc < lim) begin
      @(posedge clk_sys_in);
      #1;
      cyc++;
      hit = w ? (watch_irq_out === 1'b1) : (interval_irq_out === 1'b1);
    end
    if (!hit) begin
      fail_count++;
      $display("[FAIL] request pulse expected 1 seen 0");
      results();
    end
  endtask
  // first pulse may come late, the gap from it to the second pulse is exact
  task automatic measure(input bit w, input logic [31:0] mode, input int exp);
    wr(wtim_pkg::OFS_MODE, 32'h0000_0000);
    wr(wtim_pkg::OFS_MODE, mode);
    wait_irq(w, 2 * exp + 300, n);
    wait_irq(w, exp + 8, n);
    chk("period", exp, n);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    logic [3:0] a [5];
    a = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
    foreach (a[i]) begin
      rd(a[i], rv);
      chk("reset value", 32'h0000_0000, rv);
    end
  endtask
  task automatic t_interval();
    for (int c = 0; c < 3; c++) begin
      measure(1'b0, 32'h0000_0001 | (c << 4), 128 << (4 + c));
    end
  endtask
  task automatic t_watch();
    measure(1'b1, 32'h0000_000F, 128 << 4);
    measure(1'b1, 32'h0000_000B, 128 << 5);
  endtask
  task automatic t_sub();
    measure(1'b0, 32'h0000_0081, SUB_PER << 4);
  endtask
  task automatic t_zero();
    wr(wtim_pkg::OFS_MODE, 32'h0000_0083);
    repeat (600 * SUB_PER) @(posedge clk_sys_in);
    rd(wtim_pkg::OFS_STATE, rv);
    chk("counter", 32'h0000_0001, {27'h0, rv[20:16]});
    wr(wtim_pkg::OFS_MODE, 32'h0000_0081);
    rd(wtim_pkg::OFS_STATE, rv);
    chk("counter", 32'h0000_0000, {27'h0, rv[20:16]});
    chk("prescaler live", 32'h0000_0001, {31'h0, |rv[10:0]});
    wr(wtim_pkg::OFS_MODE, 32'h0000_0080);
    rd(wtim_pkg::OFS_STATE, rv);
    chk("state", 32'h0000_0000, rv);
    wr(wtim_pkg::OFS_MODE, 32'h0000_0000);
  endtask
  task automatic t_irq();
    rd(wtim_pkg::OFS_IRQ_STATUS, rv);
    chk("status", 32'h0000_0003, rv);
    chk("irq", 32'h0000_0000, {31'h0, irq_out});
    wr(wtim_pkg::OFS_IRQ_MASK, 32'h0000_0002);
    #1 chk("irq", 32'h0000_0001, {31'h0, irq_out});
    wr(wtim_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    #1 chk("irq", 32'h0000_0000, {31'h0, irq_out});
    wr(wtim_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    rd(wtim_pkg::OFS_IRQ_STATUS, rv);
    chk("status", 32'h0000_0002, rv);
    wr(wtim_pkg::OFS_IRQ_MASK, 32'h0000_0003);
    #1 chk("irq", 32'h0000_0001, {31'h0, irq_out});
    wr(wtim_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    #1 chk("irq", 32'h0000_0000, {31'h0, irq_out});
    rd(wtim_pkg::OFS_IRQ_MASK, rv);
    chk("mask", 32'h0000_0003, rv);
    // a live interval event must reach the level output through the mask
    wr(wtim_pkg::OFS_MODE, 32'h0000_0001);
    wait_irq(1'b0, 4400, n);
    @(posedge clk_sys_in);
    #1 chk("irq", 32'h0000_0001, {31'h0, irq_out});
    wr(wtim_pkg::OFS_MODE, 32'h0000_0000);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    rstn_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 32'h0000_0000;
    repeat (20) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    t_reset();
    t_interval();
    t_watch();
    t_sub();
    t_zero();
    t_irq();
    results();
  end
endmodule
bind wtim_top wtim_top_sva #(.SUB_PER(8)) i_wtim_top_sva (.clk_sys_in(clk_sys_in),
  .rstn_in(rstn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .sub_clk_in(sub_clk_in), .watch_irq_out(watch_irq_out),
  .interval_irq_out(interval_irq_out), .irq_out(irq_out));
